// [bdc_pkg.sv]
// shared constants for the bias dac control link and both ends
package bdc_pkg;
  // ***************
  // device register map
  // ***************
  localparam logic [15:0] ADDR_CODES = 16'h2120;
  localparam logic [15:0] ADDR_SWITCH = 16'h2124;
  localparam logic [15:0] ADDR_CONFIG = 16'h2128;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0002;
  localparam logic [31:0] CONFIG_MASK = 32'h0000_007E;
  localparam logic [31:0] CODES_MASK = 32'h0003_FFFF;
  localparam logic [31:0] SWITCH_MASK = 32'h0000_003F;
  localparam int BIAS_LSB = 0;
  localparam int ZERO_LSB = 12;
  localparam int PWDN_BIT = 1;
  localparam int REFSEL_BIT = 2;
  localparam int BMUX_BIT = 3;
  localparam int ZMUX_BIT = 4;
  localparam int MODE_BIT = 5;
  localparam int SRC_BIT = 6;
  localparam int OVR_BIT = 5;
  // switch patterns, bit n is switch n, one means closed
  localparam logic [4:0] SW_NORMAL = 5'h0C;
  localparam logic [4:0] SW_DIAG = 5'h11;
  // ***************
  // code update latency in system clocks
  // ***************
  localparam int LAT_FAST_CYC = 10;
  localparam int LAT_SLOW_CYC = 1;
  // ***************
  // host wishbone register map
  // ***************
  localparam logic [4:0] HOST_ADDR = 5'h00;
  localparam logic [4:0] HOST_WDATA = 5'h04;
  localparam logic [4:0] HOST_CTRL = 5'h08;
  localparam logic [4:0] HOST_STATUS = 5'h0C;
  localparam logic [4:0] HOST_RDATA = 5'h10;
  localparam int CTRL_WR = 0;
  localparam int CTRL_RD = 1;
  localparam int CTRL_SLOW = 2;
endpackage

// [bdc_link_if.sv]
// register link between the host controller and the bias dac device
`timescale 1ns/1ps
`default_nettype none
interface bdc_link_if;
  logic req;
  logic we;
  logic [15:0] addr;
  logic [31:0] wdata;
  logic ack;
  logic [31:0] rdata;
  modport dev (input req, input we, input addr, input wdata,
    output ack, output rdata);
  modport host (output req, output we, output addr, output wdata,
    input ack, input rdata);
endinterface
`default_nettype wire

// [bdc_device.sv]
// bias dac control: registers, code update latency and switch drive
// Functional notes
// - bias code is code register bits 11:0
// - zero code is code register bits 17:12
// - fast clock: codes apply ten cycles later
// - slow clock: codes apply one cycle later
// - sequencer waits out latency before relying
// - wave source needs slow clock, settling respected
// - mode clear: switches two, three closed
// - mode set: switches zero, four closed
// - mode set routes zero output to fast amp
// - override bit drives switches from bits 4:0
// - software compensates bias load on zero
// - config bit 6 selects code source
// - power-down resets set, opens all switches
// - software writes both mux bits equal
`timescale 1ns/1ps
`default_nettype none
module bdc_device #(
  parameter int LAT_FAST = bdc_pkg::LAT_FAST_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  bdc_link_if.dev link,
  input wire logic slow_clk_i,
  input wire logic [11:0] wave_bias_i,
  input wire logic [5:0] wave_zero_i,
  output logic [11:0] bias_code_o,
  output logic [5:0] zero_code_o,
  output logic [4:0] switch_o,
  output logic power_down_o,
  output logic zero_to_hs_tia_o,
  output logic zero_mux_o,
  output logic bias_mux_o,
  output logic ref_sel_o
);
  import bdc_pkg::*;

  if (LAT_FAST < 1 || LAT_FAST > 255)
  begin : g_chk
    $error("LAT_FAST must be 1 to 255");
  end

  // ***************
  // register access
  // ***************
  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] cfg_q;
  logic [31:0] codes_q;
  logic [31:0] sw_q;
  logic take;
  logic wr;
  logic hit_cfg;
  logic hit_codes;
  logic hit_sw;
  logic wr_cfg;
  logic wr_codes;
  logic wr_sw;
  logic [31:0] rd_mux;

  assign take = link.req & ~ack_q;
  assign wr = take & link.we;
  assign hit_cfg = link.addr == ADDR_CONFIG;
  assign hit_codes = link.addr == ADDR_CODES;
  assign hit_sw = link.addr == ADDR_SWITCH;
  assign wr_cfg = wr & hit_cfg;
  assign wr_codes = wr & hit_codes;
  assign wr_sw = wr & hit_sw;
  assign rd_mux = hit_cfg ? cfg_q :
                  hit_codes ? codes_q :
                  hit_sw ? sw_q : 32'h0000_0000;
  assign link.ack = ack_q;
  assign link.rdata = rdata_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= take;
      if (take)
        rdata_q <= rd_mux;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_q <= CONFIG_RESET;
      codes_q <= 32'h0000_0000;
      sw_q <= 32'h0000_0000;
    end
    else
    begin
      if (wr_cfg)
        cfg_q <= link.wdata & CONFIG_MASK;
      if (wr_codes)
        codes_q <= link.wdata & CODES_MASK;
      if (wr_sw)
        sw_q <= link.wdata & SWITCH_MASK;
    end
  end

  // ***************
  // code update latency
  // ***************
  logic [17:0] pend_q;
  logic [17:0] applied_q;
  logic busy_q;
  logic [7:0] cnt_q;
  logic [7:0] lat_load;
  logic [7:0] lat_fast;
  logic [17:0] code_now;

  assign lat_fast = 8'(LAT_FAST - 1);
  // a new write restarts the wait with the fresh pair of codes
  assign lat_load = slow_clk_i ? 8'(LAT_SLOW_CYC - 1) : lat_fast;
  // the output flops take the pair on the edge the wait runs out, so the
  // outputs move exactly the counted number of cycles after the take
  assign code_now = (busy_q && cnt_q == 8'h00) ? pend_q : applied_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_q <= 18'h00000;
      applied_q <= 18'h00000;
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
    end
    else
    begin
      applied_q <= code_now;
      if (wr_codes)
      begin
        pend_q <= link.wdata[17:0];
        busy_q <= 1'b1;
        cnt_q <= lat_load;
      end
      else if (busy_q)
      begin
        if (cnt_q == 8'h00)
          busy_q <= 1'b0;
        else
          cnt_q <= cnt_q - 8'h01;
      end
    end
  end

  // ***************
  // output selection
  // ***************
  logic src_wave;
  logic pwdn;
  logic mode_diag;
  logic ovr;
  logic [4:0] sw_d;
  logic [4:0] sw_q5;
  logic [11:0] bias_d;
  logic [5:0] zero_d;
  logic [11:0] bias_q;
  logic [5:0] zero_q;

  assign src_wave = cfg_q[SRC_BIT];
  assign pwdn = cfg_q[PWDN_BIT];
  assign mode_diag = cfg_q[MODE_BIT];
  assign ovr = sw_q[OVR_BIT];
  assign bias_d = src_wave ? wave_bias_i
                           : code_now[BIAS_LSB +: 12];
  assign zero_d = src_wave ? wave_zero_i
                           : code_now[ZERO_LSB +: 6];
  // power-down first, then override, then the mode pattern
  assign sw_d = pwdn ? 5'h00 :
                ovr ? sw_q[4:0] :
                mode_diag ? SW_DIAG : SW_NORMAL;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bias_q <= 12'h000;
      zero_q <= 6'h00;
      sw_q5 <= 5'h00;
    end
    else
    begin
      bias_q <= bias_d;
      zero_q <= zero_d;
      sw_q5 <= sw_d;
    end
  end

  assign bias_code_o = bias_q;
  assign zero_code_o = zero_q;
  assign switch_o = sw_q5;
  assign power_down_o = pwdn;
  assign zero_to_hs_tia_o = mode_diag & ~pwdn;
  assign zero_mux_o = cfg_q[ZMUX_BIT];
  assign bias_mux_o = cfg_q[BMUX_BIT];
  assign ref_sel_o = cfg_q[REFSEL_BIT];
endmodule // bdc_device
`default_nettype wire

// [bdc_host.sv]
// host controller: wishbone registers driving the bias dac link
`timescale 1ns/1ps
`default_nettype none
module bdc_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  bdc_link_if.host link
);
  import bdc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_XFER = 3'b010,
    ST_SETTLE = 3'b100
  } bdc_state_e;

  // ***************
  // wishbone slave
  // ***************
  logic ack_q;
  logic [31:0] dat_q;
  logic [15:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic slow_q;
  logic done_q;
  bdc_state_e st_q;
  logic acc;
  logic wr;
  logic start_wr;
  logic start_rd;
  logic idle;
  logic [31:0] status;
  logic [31:0] rd_mux;
  logic [31:0] wmask;

  assign acc = wb_cyc_i & wb_stb_i;
  assign wr = acc & wb_we_i & ack_q;
  assign idle = st_q == ST_IDLE;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign start_wr = wr && wb_adr_i == HOST_CTRL && wb_sel_i[0] &&
                    wb_dat_i[CTRL_WR] && idle;
  assign start_rd = wr && wb_adr_i == HOST_CTRL && wb_sel_i[0] &&
                    wb_dat_i[CTRL_RD] && !wb_dat_i[CTRL_WR] && idle;
  assign status = {30'h0000_0000, done_q, !idle};
  assign rd_mux = wb_adr_i == HOST_ADDR ? {16'h0000, addr_q} :
                  wb_adr_i == HOST_WDATA ? wdata_q :
                  wb_adr_i == HOST_CTRL ? {29'h0, slow_q, 2'b00} :
                  wb_adr_i == HOST_STATUS ? status :
                  wb_adr_i == HOST_RDATA ? rdata_q : 32'h0000_0000;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      addr_q <= 16'h0000;
      wdata_q <= 32'h0000_0000;
      slow_q <= 1'b0;
    end
    else
    begin
      ack_q <= acc & ~ack_q;
      if (acc && !ack_q)
        dat_q <= rd_mux;
      if (wr && wb_adr_i == HOST_ADDR)
        addr_q <= (wb_dat_i[15:0] & wmask[15:0]) | (addr_q & ~wmask[15:0]);
      if (wr && wb_adr_i == HOST_WDATA)
        wdata_q <= (wb_dat_i & wmask) | (wdata_q & ~wmask);
      if (wr && wb_adr_i == HOST_CTRL && wb_sel_i[0])
        slow_q <= wb_dat_i[CTRL_SLOW];
    end
  end

  // ***************
  // link sequencer
  // ***************
  logic req_q;
  logic we_q;
  logic [31:0] out_q;
  logic [3:0] cnt_q;
  logic [31:0] wfix;
  logic to_codes;
  logic [15:0] laddr_q;

  // keep the two mux select bits equal on config writes
  assign wfix = addr_q == ADDR_CONFIG ?
    {wdata_q[31:ZMUX_BIT + 1], wdata_q[BMUX_BIT], wdata_q[BMUX_BIT:0]}
    : wdata_q;
  // the link address is frozen at start so host writes cannot move it
  assign to_codes = we_q && laddr_q == ADDR_CODES;
  assign link.req = req_q;
  assign link.we = we_q;
  assign link.addr = laddr_q;
  assign link.wdata = out_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_q <= ST_IDLE;
      req_q <= 1'b0;
      we_q <= 1'b0;
      out_q <= 32'h0000_0000;
      rdata_q <= 32'h0000_0000;
      cnt_q <= 4'h0;
      laddr_q <= 16'h0000;
      done_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          if (start_wr || start_rd)
          begin
            req_q <= 1'b1;
            we_q <= start_wr;
            out_q <= wfix;
            laddr_q <= addr_q;
            done_q <= 1'b0;
            st_q <= ST_XFER;
          end
        end
        ST_XFER:
        begin
          if (link.ack)
          begin
            req_q <= 1'b0;
            if (!we_q)
              rdata_q <= link.rdata;
            cnt_q <= slow_q ? 4'(LAT_SLOW_CYC) : 4'(LAT_FAST_CYC);
            st_q <= to_codes ? ST_SETTLE : ST_IDLE;
            done_q <= !to_codes;
          end
        end
        ST_SETTLE:
        begin
          // stay busy until the new codes reach the outputs
          if (cnt_q == 4'h1)
          begin
            st_q <= ST_IDLE;
            done_q <= 1'b1;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        end
        default:
        begin
          st_q <= ST_IDLE;
          req_q <= 1'b0;
        end
      endcase
    end
  end
endmodule // bdc_host
`default_nettype wire

// [bdc_props.sv]
// link and switch checks for the bias dac control
`timescale 1ns/1ps
`default_nettype none
module bdc_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req,
  input wire logic we,
  input wire logic [15:0] addr,
  input wire logic [31:0] wdata,
  input wire logic ack,
  input wire logic [31:0] rdata,
  input wire logic [4:0] switch_o,
  input wire logic power_down_o,
  input wire logic zero_to_hs_tia_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence take_s;
    req && !ack;
  endsequence
  ack_resp_a: assert property (take_s |=> ack)
    else $error("link ack missing");
  req_hold_a: assert property (take_s |=> req)
    else $error("link request dropped early");
  word_hold_a: assert property (take_s |=> $stable({we, addr, wdata}))
    else $error("link word changed in flight");
  ack_pulse_a: assert property (ack |=> !ack)
    else $error("link ack too long");
  ack_src_a: assert property (ack |-> $past(req))
    else $error("link ack without request");
  req_drop_a: assert property (ack |=> !req)
    else $error("link request not released");
  rdata_hold_a: assert property (!take_s |=> $stable(rdata))
    else $error("link read data changed without a take");
  rst_vals_a: assert property ($fell(rst_i) |-> !ack && power_down_o)
    else $error("reset values wrong");
  pwdn_open_a: assert property (
    power_down_o && $past(power_down_o) |-> switch_o == 5'h00)
    else $error("switch closed while powered down");
  diag_route_a: assert property (zero_to_hs_tia_o |-> !power_down_o)
    else $error("zero output routed while powered down");
endmodule // bdc_props
`default_nettype wire

// [bdc_tb.sv]
// self-checking bench for the bias dac host and device
`timescale 1ns/1ps
`default_nettype none
module bdc_tb;
  import bdc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wwe = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic slow = 1'b0;
  logic [11:0] wv_b = 12'h000;
  logic [5:0] wv_z = 6'h00;
  logic [11:0] bias;
  logic [5:0] zero;
  logic [4:0] sw;
  logic pd;
  logic hs;
  int miscompares = 0;
  int compares = 0;
  logic [31:0] q[$];
  logic [31:0] d;
  bdc_link_if link ();
  always #25 clk_i = ~clk_i;
  bdc_host bdc_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .link(link));
  bdc_device bdc_device_i (.clk_i(clk_i), .rst_i(rst_i), .link(link),
    .slow_clk_i(slow), .wave_bias_i(wv_b), .wave_zero_i(wv_z),
    .bias_code_o(bias), .zero_code_o(zero), .switch_o(sw),
    .power_down_o(pd), .zero_to_hs_tia_o(hs), .zero_mux_o(),
    .bias_mux_o(), .ref_sel_o());
  bdc_props bdc_props_i (.clk_i(clk_i), .rst_i(rst_i), .req(link.req),
    .we(link.we), .addr(link.addr), .wdata(link.wdata), .ack(link.ack),
    .rdata(link.rdata), .switch_o(sw), .power_down_o(pd),
    .zero_to_hs_tia_o(hs));
  task automatic wrap_up();
    if (miscompares == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    compares++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [4:0] a,
    input logic [31:0] v);
    @(posedge clk_i);
    {cyc, stb, wwe} <= {2'b11, w};
    adr <= a;
    wdat <= v;
    // no count here: the watchdog ends a wait that never sees ack
    do
      @(negedge clk_i);
    while (ack !== 1'b1);
    @(posedge clk_i);
    {cyc, stb} <= 2'b00;
  endtask
  // read results are compared in order as the host acks them
  always @(negedge clk_i)
    if (ack === 1'b1 && wwe === 1'b0)
      chk("rdata", q.pop_front(), rdat);
  task automatic dev(input logic w, input logic [15:0] a,
    input logic [31:0] v);
    wb(1'b1, HOST_ADDR, {16'h0000, a});
    wb(1'b1, HOST_WDATA, v);
    wb(1'b1, HOST_CTRL, {29'h0, slow, ~w, w});
  endtask
  task automatic fin();
    repeat (20) @(posedge clk_i);
    q.push_back(32'h2);
    wb(1'b0, HOST_STATUS, 32'h0);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    dev(1'b1, a, v);
    fin();
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    dev(1'b0, a, 32'h0);
    fin();
    q.push_back(e);
    wb(1'b0, HOST_RDATA, 32'h0);
  endtask
  task automatic cw(input logic [31:0] v);
    logic [17:0] o;
    o = {zero, bias};
    dev(1'b1, ADDR_CODES, v);
    // the next rising edge takes the word; outputs move latency edges later
    do
      @(negedge clk_i);
    while (!(link.req === 1'b1 && link.ack !== 1'b1));
    repeat (slow ? LAT_SLOW_CYC : LAT_FAST_CYC) @(posedge clk_i);
    @(negedge clk_i);
    chk("old codes", {14'h0, o}, {14'h0, zero, bias});
    @(negedge clk_i);
    chk("bias", {20'h0, v[11:0]}, {20'h0, bias});
    chk("zero", {26'h0, v[17:12]}, {26'h0, zero});
    fin();
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(93));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("pwdn", 32'h1, {31'h0, pd});
    rd(ADDR_CONFIG, CONFIG_RESET);
    wr(ADDR_CONFIG, 32'h0);
    chk("normal", {27'h0, SW_NORMAL}, {27'h0, sw});
    wr(ADDR_CONFIG, 32'h20);
    chk("diag", {27'h0, SW_DIAG}, {27'h0, sw});
    chk("route", 32'h1, {31'h0, hs});
    d = $urandom;
    wr(ADDR_SWITCH, {26'h0, 1'b1, d[4:0]});
    chk("override", {27'h0, d[4:0]}, {27'h0, sw});
    wr(ADDR_CONFIG, 32'h22);
    chk("pwdn open", 32'h0, {27'h0, sw});
    wr(ADDR_SWITCH, 32'h0);
    wr(ADDR_CONFIG, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      slow <= i[0];
      d = $urandom;
      if (d[11:0] != 12'h000 && d[11:0] < {d[17:12], 6'h00})
        d[11:0] = d[11:0] - 12'h001;
      cw(d);
    end
    rd(ADDR_CODES, d & CODES_MASK);
    rd(16'h2130, 32'h0);
    slow <= 1'b1;
    wv_b <= 12'($urandom);
    wv_z <= 6'($urandom);
    wr(ADDR_CONFIG, 32'h40);
    chk("wave bias", {20'h0, wv_b}, {20'h0, bias});
    chk("wave zero", {26'h0, wv_z}, {26'h0, zero});
    wrap_up();
  end
endmodule // bdc_tb
`default_nettype wire
